// ### acc_conv_ctrl.sv
/*
 * conversion-control logic of a 12-bit converter behind an apb slave:
 * start by software bit or timer trigger, sequence modes, retrigger halt,
 * clock-switch hang and interrupt status.
 * assumes one 40 mhz clock, synchronous trigger input, analog result input.
 */
// Summary of operation
// - timer trigger, single mode: any write to first control with conversion enable set re-arms a sample
// - normally only setting conversion enable arms; single timer mode departs from that
// - a trigger arriving while busy halts all later conversions in every mode other than single
// - trigger overrun flag is never set by an overrun, so cannot detect it
// - subsystem clock selected with off request set: switching source stops converter
// - that hang happens only for divider settings divide by three, five, seven
// - hang leaves only by reset, power-up clear, brownout or power cycle
`timescale 1ns/100ps
`default_nettype none
`include "acc_consts.svh"
module acc_conv_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire acc_pkg::acc_apb_req_s apb_req,
  output acc_pkg::acc_apb_rsp_s apb_rsp,
  // timer sample trigger and analog result
  input wire logic timer_trigger,
  input wire logic [`ACC_RES_W-1:0] analog_sample,
  // status
  output logic converter_busy_flag,
  output logic irq
);
  import acc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [`ACC_CTL0_W-1:0] converter_control_first;
  logic [`ACC_CTL1_W-1:0] converter_control_second;
  logic [`ACC_CLK_W-1:0] clock_system_control_four;
  logic [`ACC_IFG_W-1:0] irq_status;
  logic [`ACC_IFG_W-1:0] irq_mask;
  logic [`ACC_RES_W-1:0] result;
  acc_state_e state;
  logic [`ACC_CNT_W-1:0] cnt;
  logic armed;

  logic wr_acc, rd_acc;
  logic wr_ctl0, wr_ctl1;
  logic conversion_enable_bit, converter_power_on_bit;
  logic [1:0] sequence_mode_field;
  logic sample_pulse_mode_bit, trigger_select;
  logic [1:0] conversion_clock_select;
  logic [2:0] conversion_clock_divider;
  logic subsystem_clock_off_request;
  logic next_enc;
  logic sw_start, tmr_start, start_req;
  logic done_ev, halt_ev, hang_ev;
  logic odd_div, clk_switch;
  logic [1:0] next_ssel;
  logic [2:0] next_div;

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_acc = apb_req.psel && !apb_req.pwrite;
  assign wr_ctl0 = wr_acc && apb_req.paddr == `ACC_OFF_CTL0;
  assign wr_ctl1 = wr_acc && apb_req.paddr == `ACC_OFF_CTL1;

  assign conversion_enable_bit = converter_control_first[`ACC_CTL0_ENC];
  assign converter_power_on_bit = converter_control_first[`ACC_CTL0_ON];
  assign sequence_mode_field = converter_control_second[`ACC_CTL1_SEQ_HI:`ACC_CTL1_SEQ_LO];
  assign sample_pulse_mode_bit = converter_control_second[`ACC_CTL1_SHP];
  assign trigger_select = converter_control_second[`ACC_CTL1_TRG];
  assign conversion_clock_select = converter_control_second[`ACC_CTL1_SSEL_HI:`ACC_CTL1_SSEL_LO];
  assign conversion_clock_divider = converter_control_second[`ACC_CTL1_DIV_HI:`ACC_CTL1_DIV_LO];
  assign subsystem_clock_off_request = clock_system_control_four[`ACC_CLK_SMOFF];
  assign next_ssel = apb_req.pwdata[`ACC_CTL1_SSEL_HI:`ACC_CTL1_SSEL_LO];
  assign next_div = apb_req.pwdata[`ACC_CTL1_DIV_HI:`ACC_CTL1_DIV_LO];
  assign next_enc = apb_req.pwdata[`ACC_CTL0_ENC];

  // ****************************************
  // apb write side
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      converter_control_first <= '0;
    end else if (wr_ctl0) begin
      // start bit is self clearing
      converter_control_first <= apb_req.pwdata[`ACC_CTL0_W-1:0] & ~(`ACC_CTL0_W'(1) << `ACC_CTL0_SC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      converter_control_second <= '0;
    end else if (wr_ctl1) begin
      converter_control_second <= apb_req.pwdata[`ACC_CTL1_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clock_system_control_four <= '0;
    end else if (wr_acc && apb_req.paddr == `ACC_OFF_CLK) begin
      clock_system_control_four <= apb_req.pwdata[`ACC_CLK_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_mask <= '0;
    end else if (wr_acc && apb_req.paddr == `ACC_OFF_IE) begin
      irq_mask <= apb_req.pwdata[`ACC_IFG_W-1:0];
    end
  end

  // ****************************************
  // start logic
  // ****************************************
  // arming: timer triggers fire only while armed and enabled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (wr_ctl0 && sequence_mode_field == `ACC_SEQ_SINGLE && trigger_select) begin
      armed <= next_enc;
    end else if (wr_ctl0 && next_enc && !conversion_enable_bit) begin
      armed <= 1'b1;
    end else if (wr_ctl0 && !next_enc) begin
      armed <= 1'b0;
    end else if (tmr_start && sequence_mode_field == `ACC_SEQ_SINGLE) begin
      armed <= 1'b0;
    end
  end

  assign sw_start = wr_ctl0 && apb_req.pwdata[`ACC_CTL0_SC] && next_enc && !trigger_select;
  assign tmr_start = trigger_select && timer_trigger && conversion_enable_bit && armed;
  assign start_req = (sw_start || tmr_start) && converter_power_on_bit;

  // ****************************************
  // clock switch hang detect
  // ****************************************
  assign odd_div = conversion_clock_divider == `ACC_DIV3 || conversion_clock_divider == `ACC_DIV5 ||
                   conversion_clock_divider == `ACC_DIV7;
  assign clk_switch = wr_ctl1 && conversion_clock_select == `ACC_SSEL_SUB && next_ssel != `ACC_SSEL_SUB;
  assign hang_ev = clk_switch && subsystem_clock_off_request && odd_div && state != ACC_HUNG;

  // ****************************************
  // conversion sequencer
  // ****************************************
  assign converter_busy_flag = state == ACC_SAMPLE || state == ACC_CONVERT;
  assign halt_ev = start_req && converter_busy_flag && sequence_mode_field != `ACC_SEQ_SINGLE;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ACC_IDLE;
      cnt <= '0;
    end else if (hang_ev || state == ACC_HUNG) begin
      state <= ACC_HUNG;
    end else if (!converter_power_on_bit) begin
      state <= ACC_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        ACC_IDLE: begin
          if (start_req) begin
            state <= ACC_SAMPLE;
            cnt <= `ACC_CNT_W'(`ACC_SAMPLE_CYC - 1);
          end
        end
        ACC_SAMPLE, ACC_CONVERT: begin
          if (halt_ev) begin
            state <= ACC_HALTED;
          end else if (cnt != '0) begin
            cnt <= cnt - `ACC_CNT_W'(1);
          end else if (state == ACC_SAMPLE) begin
            state <= ACC_CONVERT;
            cnt <= `ACC_CNT_W'(`ACC_CONV_CYC - 1);
          end else if (sequence_mode_field != `ACC_SEQ_SINGLE && conversion_enable_bit && !sample_pulse_mode_bit) begin
            state <= ACC_SAMPLE;
            cnt <= `ACC_CNT_W'(`ACC_SAMPLE_CYC - 1);
          end else begin
            state <= ACC_IDLE;
          end
        end
        ACC_HALTED: begin
          state <= ACC_HALTED;
        end
        ACC_HUNG: begin
          state <= ACC_HUNG;
        end
      endcase
    end
  end

  assign done_ev = state == ACC_CONVERT && cnt == '0 && converter_power_on_bit && !halt_ev && !hang_ev;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result <= '0;
    end else if (done_ev) begin
      result <= analog_sample;
    end
  end

  // ****************************************
  // interrupt status: set wins over write-one clear
  // ****************************************
  logic [`ACC_IFG_W-1:0] set_vec;
  logic [`ACC_IFG_W-1:0] clr_vec;
  // overrun bit never sets on a trigger overrun
  assign set_vec = {1'b0, hang_ev, halt_ev, done_ev};
  assign clr_vec = (wr_acc && apb_req.paddr == `ACC_OFF_IFG) ? apb_req.pwdata[`ACC_IFG_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_vec) | set_vec;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // apb read side
  // ****************************************
  logic [31:0] next_rdata;
  logic next_err;
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    unique case (apb_req.paddr)
      `ACC_OFF_CTL0: next_rdata = 32'(converter_control_first);
      `ACC_OFF_CTL1: next_rdata = 32'(converter_control_second);
      `ACC_OFF_STAT: next_rdata = {28'h0, armed, state == ACC_HUNG, state == ACC_HALTED, converter_busy_flag};
      `ACC_OFF_IFG: next_rdata = 32'(irq_status);
      `ACC_OFF_IE: next_rdata = 32'(irq_mask);
      `ACC_OFF_CLK: next_rdata = 32'(clock_system_control_four);
      `ACC_OFF_RESULT: next_rdata = 32'(result);
      `ACC_OFF_HWREV: next_rdata = `ACC_HWREV;
      default: next_err = 1'b1;
    endcase
  end

  // data registered in setup phase, answered in first access cycle
  logic [31:0] rdata_q;
  logic rerr_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= '0;
      rerr_q <= 1'b0;
    end else if (apb_req.psel && !apb_req.penable) begin
      rdata_q <= rd_acc ? next_rdata : '0;
      rerr_q <= next_err;
    end
  end

  assign apb_rsp = '{pready: 1'b1, pslverr: rerr_q, prdata: rdata_q};
endmodule // acc_conv_ctrl
`default_nettype wire

// ### acc_consts.svh
/*
 * constants for the converter conversion-control block: register offsets,
 * field positions, codes and timing counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ****************************************
// register byte offsets (apb, word aligned)
// ****************************************
`define ACC_OFF_CTL0 12'h000
`define ACC_OFF_CTL1 12'h004
`define ACC_OFF_STAT 12'h008
`define ACC_OFF_IFG 12'h00c
`define ACC_OFF_IE 12'h010
`define ACC_OFF_CLK 12'h014
`define ACC_OFF_RESULT 12'h018
`define ACC_OFF_HWREV 12'h01c

// ****************************************
// first control register fields
// ****************************************
`define ACC_CTL0_ENC 0
`define ACC_CTL0_SC 1
`define ACC_CTL0_ON 4
`define ACC_CTL0_W 8

// ****************************************
// second control register fields
// ****************************************
`define ACC_CTL1_SEQ_LO 1
`define ACC_CTL1_SEQ_HI 2
`define ACC_CTL1_SHP 3
`define ACC_CTL1_TRG 4
`define ACC_CTL1_SSEL_LO 5
`define ACC_CTL1_SSEL_HI 6
`define ACC_CTL1_DIV_LO 8
`define ACC_CTL1_DIV_HI 10
`define ACC_CTL1_W 11

// ****************************************
// clock control fields
// ****************************************
`define ACC_CLK_SMOFF 0
`define ACC_CLK_W 1

// ****************************************
// codes
// ****************************************
`define ACC_SEQ_SINGLE 2'h0
`define ACC_SSEL_SUB 2'h3
`define ACC_DIV3 3'h2
`define ACC_DIV5 3'h4
`define ACC_DIV7 3'h6

// ****************************************
// interrupt flag bits
// ****************************************
`define ACC_IFG_DONE 0
`define ACC_IFG_HALT 1
`define ACC_IFG_HANG 2
`define ACC_IFG_OVR 3
`define ACC_IFG_W 4

// ****************************************
// timing: sample and conversion time in ns at 40 mhz
// ****************************************
`define ACC_CLK_NS 25
`define ACC_SAMPLE_NS 400
`define ACC_CONV_NS 1300
`define ACC_SAMPLE_CYC ((`ACC_SAMPLE_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CONV_CYC ((`ACC_CONV_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CNT_W 8
`define ACC_RES_W 12

// arbitrary hardware revision value
`define ACC_HWREV 32'h0000_00a5

`endif

// ### acc_pkg.sv
/*
 * types for the conversion-control block.
 * assumes acc_consts.svh is reachable by bare name.
 */
`include "acc_consts.svh"
package acc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } acc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } acc_apb_rsp_s;

  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_SAMPLE,
    ACC_CONVERT,
    ACC_HALTED,
    ACC_HUNG
  } acc_state_e;
endpackage

// ### acc_timer_model.sv
/* timer model: one-cycle sample trigger per request.
   assumes the bench asks only while the converter is idle. */
`timescale 1ns/100ps
`default_nettype none
module acc_timer_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // request and trigger
  input wire logic fire,
  output logic timer_trigger
);
  // a held request gives a pulse every other cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer_trigger <= 1'b0;
    end else begin
      timer_trigger <= fire && !timer_trigger;
    end
  end
endmodule // acc_timer_model
`default_nettype wire

// ### acc_conv_ctrl_props.sv
/* port checker for the conversion-control block.
   assumes acc_pkg and acc_consts.svh; bound below. */
`timescale 1ns/100ps
`default_nettype none
`include "acc_consts.svh"
module acc_conv_ctrl_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb
  input wire acc_pkg::acc_apb_req_s apb_req,
  input wire acc_pkg::acc_apb_rsp_s apb_rsp,
  // converter
  input wire logic timer_trigger,
  input wire logic [`ACC_RES_W-1:0] analog_sample,
  input wire logic converter_busy_flag,
  input wire logic irq
);
  import acc_pkg::*;
  logic en, trg, smoff, hang, armed, spent;
  logic [1:0] seq, ssel;
  logic [2:0] div;
  wire [31:0] d = apb_req.pwdata;
  wire w = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire r = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  wire w0 = w && apb_req.paddr == `ACC_OFF_CTL0;
  wire w1 = w && apb_req.paddr == `ACC_OFF_CTL1;
  wire rs = r && apb_req.paddr == `ACC_OFF_STAT;
  wire busy = converter_busy_flag;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****
  // shadow of control fields
  // ****
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {en, trg, seq, ssel, div, smoff, hang} <= '0;
    end else begin
      if (w0) en <= d[0];
      if (w1) {div, ssel, trg, seq} <= {d[10:8], d[6:4], d[2:1]};
      if (w1 && ssel == 2'h3 && d[6:5] != 2'h3 && smoff && div inside {3'h2, 3'h4, 3'h6}) hang <= 1'b1;
      if (w && apb_req.paddr == `ACC_OFF_CLK) smoff <= d[0];
    end
  end
  // timer single mode: armed by a write, spent by a trigger
  always_ff @(posedge clk_sys) begin
    if (reset || w1) begin
      {armed, spent} <= '0;
    end else if (w0) begin
      {armed, spent} <= {d[0] && d[4] && trg && seq == 2'h0, 1'b0};
    end else if (armed && timer_trigger) begin
      {armed, spent} <= 2'h1;
    end
  end
  // ****
  // properties
  // ****
  property p_rearm;
    armed && !hang && timer_trigger && !busy && !w |=> busy [*8];
  endproperty
  a_rearm: assert property (p_rearm) else $error("armed trigger gave no sample");
  property p_spent;
    spent && timer_trigger && !busy && !w |=> !busy;
  endproperty
  a_spent: assert property (p_spent) else $error("unarmed trigger sampled");
  property p_halt;
    w0 && d[1:0] == 2'h3 && d[4] && !trg && seq != 2'h0 && busy |=> !busy [*4];
  endproperty
  a_halt: assert property (p_halt) else $error("retrigger did not halt");
  property p_ovr;
    r && apb_req.paddr == `ACC_OFF_IFG |-> !apb_rsp.prdata[`ACC_IFG_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag set");
  property p_hang_stop;
    hang |-> !busy;
  endproperty
  a_hang_stop: assert property (p_hang_stop) else $error("busy while hung");
  property p_hang_div;
    rs && apb_rsp.prdata[2] |-> hang;
  endproperty
  a_hang_div: assert property (p_hang_div) else $error("hang without its cause");
  property p_hang_keep;
    rs && hang |-> apb_rsp.prdata[2];
  endproperty
  a_hang_keep: assert property (p_hang_keep) else $error("hang left early");
  property p_gate;
    !en && timer_trigger && !busy && !w |=> !busy [*2];
  endproperty
  a_gate: assert property (p_gate) else $error("trigger taken while disabled");
  c_halt: cover property (w0 && d[1:0] == 2'h3 && busy);
  c_hang: cover property (rs && hang);
  c_timer: cover property (armed && timer_trigger);
endmodule // acc_conv_ctrl_props
bind acc_conv_ctrl acc_conv_ctrl_props u_acc_conv_ctrl_props (.clk_sys(clk_sys), .reset(reset),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .timer_trigger(timer_trigger), .analog_sample(analog_sample),
  .converter_busy_flag(converter_busy_flag), .irq(irq));
`default_nettype wire

// ### acc_conv_ctrl_tb_top.sv
/* bench for the conversion-control block: apb tasks and directed tests.
   assumes acc_pkg, acc_consts.svh, the timer model and the checker. */
`timescale 1ns/100ps
`default_nettype none
`include "acc_consts.svh"
module acc_conv_ctrl_tb_top;
  import acc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fire = 1'b0;
  logic timer_trigger, converter_busy_flag, irq, rerr, hung;
  logic [11:0] analog_sample = 12'h5a3;
  logic [31:0] rdat;
  acc_apb_req_s apb_req = '0;
  acc_apb_rsp_s apb_rsp;
  int errors = 0;
  int check_count = 0;
  acc_conv_ctrl u_acc_conv_ctrl (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer_trigger(timer_trigger), .analog_sample(analog_sample), .converter_busy_flag(converter_busy_flag),
    .irq(irq));
  acc_timer_model u_acc_timer_model (.clk_sys(clk_sys), .reset(reset), .fire(fire), .timer_trigger(timer_trigger));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rdat & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // software polls busy before the next start
  task automatic idle();
    for (int i = 0; i < 200 && converter_busy_flag !== 1'b0; i++) @(negedge clk_sys);
  endtask
  task automatic trig(input string what, input logic e);
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    cyc(3);
    chk(what, converter_busy_flag, e);
  endtask
  task automatic rst();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task automatic end_of_test();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 28; a += 4) rd(a[11:0], '1, 32'h0, "reset value");
    rd(12'h020, '1, 32'h0, "unmapped read");
    chk("unmapped err", rerr, 1'b1);
    rd(`ACC_OFF_HWREV, '1, `ACC_HWREV, "hw revision");
    wr(`ACC_OFF_IE, 32'h1);
    // power-on must already be set when the start write lands
    wr(`ACC_OFF_CTL0, 32'h10);
    wr(`ACC_OFF_CTL0, 32'h13);
    cyc(1);
    chk("busy", converter_busy_flag, 1'b1);
    idle();
    rd(`ACC_OFF_RESULT, '1, 32'h5a3, "result");
    rd(`ACC_OFF_IFG, 32'hf, 32'h1, "done flag");
    cyc(1);
    chk("irq", irq, 1'b1);
    wr(`ACC_OFF_IE, 32'h0);
    cyc(1);
    chk("irq masked", irq, 1'b0);
    wr(`ACC_OFF_IE, 32'h1);
    wr(`ACC_OFF_IFG, 32'h1);
    cyc(1);
    chk("irq cleared", irq, 1'b0);
    // second start while busy in sequence mode
    rst();
    wr(`ACC_OFF_CTL1, 32'h2);
    wr(`ACC_OFF_CTL0, 32'h10);
    wr(`ACC_OFF_CTL0, 32'h13);
    wr(`ACC_OFF_CTL0, 32'h13);
    rd(`ACC_OFF_STAT, 32'h7, 32'h2, "halted");
    rd(`ACC_OFF_IFG, 32'ha, 32'h2, "halt flag");
    wr(`ACC_OFF_CTL0, 32'h0);
    wr(`ACC_OFF_CTL0, 32'h11);
    wr(`ACC_OFF_CTL0, 32'h13);
    cyc(1);
    chk("restart", converter_busy_flag, 1'b1);
    // repeat mode keeps converting until a retrigger halts it
    rst();
    wr(`ACC_OFF_CTL1, 32'h6);
    wr(`ACC_OFF_CTL0, 32'h10);
    wr(`ACC_OFF_CTL0, 32'h13);
    cyc(100);
    chk("repeat busy", converter_busy_flag, 1'b1);
    wr(`ACC_OFF_CTL0, 32'h13);
    rd(`ACC_OFF_STAT, 32'h7, 32'h2, "repeat halted");
    // timer triggers in single mode
    rst();
    wr(`ACC_OFF_CTL1, 32'h10);
    wr(`ACC_OFF_CTL0, 32'h10);
    trig("gated trigger", 1'b0);
    wr(`ACC_OFF_CTL0, 32'h11);
    trig("armed trigger", 1'b1);
    idle();
    trig("spent trigger", 1'b0);
    wr(`ACC_OFF_CTL0, 32'h11);
    trig("rewrite arms", 1'b1);
    idle();
    wr(`ACC_OFF_CTL0, 32'h10);
    wr(`ACC_OFF_CTL0, 32'h11);
    trig("enable toggle arms", 1'b1);
    // clock source switch per divider; last pass has the off request clear
    for (int k = 0; k < 9; k++) begin
      hung = k == 2 || k == 4 || k == 6;
      rst();
      wr(`ACC_OFF_CLK, 32'(k < 8));
      wr(`ACC_OFF_CTL1, 32'h60 | 32'((k < 8 ? k : 2) << 8));
      wr(`ACC_OFF_CTL1, 32'((k < 8 ? k : 2) << 8));
      wr(`ACC_OFF_CTL0, 32'h10);
      wr(`ACC_OFF_CTL0, 32'h13);
      cyc(1);
      chk("hang stops", converter_busy_flag, !hung);
      rd(`ACC_OFF_STAT, 32'h4, {29'h0, hung, 2'h0}, "hang");
      idle();
      wr(`ACC_OFF_CTL0, 32'h0);
      wr(`ACC_OFF_CTL0, 32'h13);
      rd(`ACC_OFF_STAT, 32'h4, {29'h0, hung, 2'h0}, "hang kept");
    end
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
endmodule // acc_conv_ctrl_tb_top
`default_nettype wire
